// file: hw/sdiv_unit.sv
`timescale 1ns/100ps
module sdiv_unit (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic start_in,
    input wire logic [31:0] instr_in,
    input wire logic halfword_in,
    input wire logic two_operand_in,
    input wire logic [sdiv_pkg::SDIV_RA_W-1:0] divisor_operand_in,
    input wire logic [sdiv_pkg::SDIV_RA_W-1:0] dividend_quotient_operand_in,
    input wire logic [sdiv_pkg::SDIV_RA_W-1:0] remainder_operand_in,
    input wire logic [sdiv_pkg::SDIV_W-1:0] divisor_data_in,
    input wire logic [sdiv_pkg::SDIV_W-1:0] dividend_data_in,
    input wire logic interrupt_in,
    output logic busy_out,
    output logic word_decode_out,
    output logic abort_out,
    output logic done_out,
    output logic wr_en_out,
    output logic [sdiv_pkg::SDIV_RA_W-1:0] wr_addr_out,
    output logic [sdiv_pkg::SDIV_W-1:0] wr_data_out,
    output logic flags_we_out,
    output logic overflow_flag_out,
    output logic sign_flag_out,
    output logic zero_flag_out
);
    import sdiv_pkg::*;

    // control state and its successor
    sdiv_state_t state_r;
    sdiv_state_t state_nxt;

    // latched operands and the running partial results
    logic [31:0] dvd_r;
    logic [31:0] dvs_r;
    logic [31:0] rem_r;
    logic [31:0] quo_r;
    logic neg_q_r;
    logic ovf_r;
    logic two_op_r;
    logic [4:0] qa_r;
    logic [4:0] ra_r;
    logic [5:0] cnt_r;

    // two's complement negate, shared by operand and result shaping
    function automatic logic [31:0] sdiv_neg(input logic [31:0] v);
        sdiv_neg = ~v + 32'h0000_0001;
    endfunction : sdiv_neg

    // magnitude of a signed word; the most negative value keeps its pattern, read as unsigned
    function automatic logic [31:0] sdiv_abs(input logic [31:0] v);
        sdiv_abs = v[31] ? sdiv_neg(v) : v;
    endfunction : sdiv_abs

    // give a magnitude its sign back
    function automatic logic [31:0] sdiv_sign(input logic [31:0] mag, input logic neg);
        sdiv_sign = neg ? sdiv_neg(mag) : mag;
    endfunction : sdiv_sign

    // state decode used by the datapath and the write-back port
    wire logic in_idle = (state_r == SDIV_IDLE);
    wire logic in_run = (state_r == SDIV_RUN);
    wire logic in_wrq = (state_r == SDIV_WRQ);
    wire logic in_wrr = (state_r == SDIV_WRR);
    wire logic last_step = (cnt_r == SDIV_CNT_LAST);
    wire logic abandon = in_run && interrupt_in;

    // opcode match on the two fixed fields of the word divide encoding
    wire logic lo_match = (instr_in[SDIV_LO_POS +: 6] == SDIV_LO_PAT);
    wire logic hi_match = (instr_in[SDIV_HI_POS +: 11] == SDIV_HI_WORD);
    wire logic word_match = lo_match && hi_match;

    // halfword form sign-extends the low half of the divisor; the high half is dropped
    wire logic [31:0] dvs_half = {{16{divisor_data_in[15]}}, divisor_data_in[15:0]};
    wire logic [31:0] dvs_eff = halfword_in ? dvs_half : divisor_data_in;
    wire logic div_zero = (dvs_eff == 32'h0000_0000);
    wire logic dvd_most_neg = (dividend_data_in == SDIV_MOST_NEG);
    wire logic dvs_minus_one = (dvs_eff == SDIV_MINUS_ONE);
    wire logic div_edge = dvd_most_neg && dvs_minus_one;
    wire logic go = start_in && in_idle;
    wire logic two_op_in = halfword_in && two_operand_in;

    // restoring divide step on magnitudes: shift one dividend bit in, subtract when it fits
    wire logic [32:0] trial = {rem_r, quo_r[31]} - {1'b0, dvs_r};
    wire logic step_ok = ~trial[32];
    wire logic [31:0] rem_step = step_ok ? trial[31:0] : {rem_r[30:0], quo_r[31]};
    wire logic [31:0] quo_step = {quo_r[30:0], step_ok};

    // signed results: quotient truncates toward zero, remainder follows the dividend
    wire logic [31:0] q_final = sdiv_sign(quo_r, neg_q_r);
    wire logic [31:0] r_final = sdiv_sign(rem_r, dvd_r[31]);
    // both overflow cases hand back the most negative word as quotient
    wire logic [31:0] q_out = ovf_r ? SDIV_MOST_NEG : q_final;

    // flags always follow the quotient, even when the remainder is the only write
    wire logic q_neg = q_out[31];
    wire logic q_zero = (q_out == 32'h0000_0000);

    // one write only for the two-operand halfword form or a shared destination
    wire logic same_dest = (qa_r == ra_r);
    wire logic single_wr = two_op_r || same_dest;
    // the remainder takes the quotient's slot when both targets match, except in the two-operand halfword form
    wire logic rem_slot = in_wrr || (in_wrq && same_dest && !two_op_r);
    wire logic [4:0] wr_addr_sel = rem_slot ? ra_r : qa_r;
    wire logic [31:0] wr_data_sel = rem_slot ? r_final : q_out;
    wire logic wr_sel = in_wrq || in_wrr; // the divisor address is never driven
    // the write states ignore interrupts, so completion never depends on one
    wire logic finish = (in_wrq && single_wr) || in_wrr;

    // next state; an interrupt abandons only the iterating state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SDIV_IDLE: begin
                if (go) state_nxt = SDIV_RUN;
            end
            SDIV_RUN: begin
                if (interrupt_in) state_nxt = SDIV_IDLE;
                else if (last_step) state_nxt = SDIV_WRQ;
            end
            SDIV_WRQ: begin
                state_nxt = single_wr ? SDIV_IDLE : SDIV_WRR;
            end
            SDIV_WRR: begin
                state_nxt = SDIV_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            state_r <= SDIV_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // operand latch at the start, before any destination can be written
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            dvd_r <= 32'h0000_0000;
            dvs_r <= 32'h0000_0000;
            neg_q_r <= 1'b0;
            ovf_r <= 1'b0;
        end else if (go) begin
            dvd_r <= dividend_data_in;
            dvs_r <= sdiv_abs(dvs_eff);
            neg_q_r <= dividend_data_in[31] ^ dvs_eff[31];
            ovf_r <= div_zero || div_edge;
        end
    end

    // destination addresses and form, held through the write-back states
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            two_op_r <= 1'b0;
            qa_r <= 5'h00;
            ra_r <= 5'h00;
        end else if (go) begin
            two_op_r <= two_op_in;
            qa_r <= dividend_quotient_operand_in;
            ra_r <= remainder_operand_in;
        end
    end

    // partial remainder, shifting quotient and step counter
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            rem_r <= 32'h0000_0000;
            quo_r <= 32'h0000_0000;
            cnt_r <= 6'h00;
        end else if (go) begin
            rem_r <= 32'h0000_0000;
            quo_r <= sdiv_abs(dividend_data_in);
            cnt_r <= 6'h00;
        end else if (in_run) begin
            rem_r <= rem_step;
            quo_r <= quo_step;
            cnt_r <= cnt_r + 6'h01;
        end
    end

    // busy level and the completion and abort pulses
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            busy_out <= 1'b0;
            abort_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            busy_out <= (state_nxt != SDIV_IDLE);
            abort_out <= abandon;
            done_out <= finish;
        end
    end

    // registered opcode decode
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            word_decode_out <= 1'b0;
        end else begin
            word_decode_out <= word_match;
        end
    end

    // write-back port toward the register file
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            wr_en_out <= 1'b0;
            wr_addr_out <= 5'h00;
            wr_data_out <= 32'h0000_0000;
        end else begin
            wr_en_out <= wr_sel;
            wr_addr_out <= wr_addr_sel;
            wr_data_out <= wr_data_sel;
        end
    end

    // flag port; carry and saturation have no port here and are never touched
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            flags_we_out <= 1'b0;
            overflow_flag_out <= 1'b0;
            sign_flag_out <= 1'b0;
            zero_flag_out <= 1'b0;
        end else begin
            flags_we_out <= in_wrq; // only these three flags
            if (in_wrq) begin
                overflow_flag_out <= ovf_r;
                sign_flag_out <= q_neg;
                zero_flag_out <= q_zero;
            end
        end
    end
endmodule : sdiv_unit

// file: include/sdiv_pkg.sv
// Notes on behaviour
// - word divide takes the dividend from operand two, divisor from operand one.
// - word divide writes quotient to operand two, remainder to operand three.
// - decode word divide from its fixed 32-bit opcode pattern.
// - overflow flag set on overflow, cleared otherwise.
// - sign flag set when the quotient is negative, cleared otherwise.
// - zero flag set when the quotient is zero, cleared otherwise.
// - carry and saturation flags are never written by a division.
// - zero divisor signals overflow; quotient value is unspecified.
// - most negative divided by minus one signals overflow, quotient is most negative.
// - the divisor register is never written.
// - an interrupt abandons the division so it reruns from the start.
// - an aborted division commits no register or flag.
// - when both destinations match, the remainder ends in that register.
// - three-operand halfword divide writes quotient and remainder like word divide.
// - halfword divide uses only the low sixteen bits of the divisor.
// - two-operand halfword divide writes only the quotient.
package sdiv_pkg;
    localparam int SDIV_W = 32;
    localparam int SDIV_RA_W = 5;
    localparam int SDIV_STEPS = 32;
    localparam int SDIV_LO_POS = 5; // lowest bit of the fixed low-half pattern
    localparam int SDIV_HI_POS = 16; // lowest bit of the fixed high-half pattern
    localparam logic [5:0] SDIV_LO_PAT = 6'h3F; // 111111 in bits 10:5
    localparam logic [10:0] SDIV_HI_WORD = 11'h2C0; // 01011000000 in bits 26:16
    localparam logic [31:0] SDIV_MOST_NEG = 32'h8000_0000;
    localparam logic [31:0] SDIV_MINUS_ONE = 32'hFFFF_FFFF;
    localparam logic [5:0] SDIV_CNT_LAST = 6'h1F;
    typedef enum logic [1:0] {
        SDIV_IDLE = 2'b00,
        SDIV_RUN = 2'b01,
        SDIV_WRQ = 2'b11,
        SDIV_WRR = 2'b10
    } sdiv_state_t;
endpackage : sdiv_pkg

// file: tb/sdiv_checker.sv
`timescale 1ns/100ps
module sdiv_checker (
    input wire logic ref_clk_in, reset_in, start_in, interrupt_in, two_operand_in, busy_out,
    input wire logic abort_out, done_out, wr_en_out, flags_we_out, word_decode_out,
    input wire logic overflow_flag_out, sign_flag_out, zero_flag_out,
    input wire logic [31:0] instr_in, wr_data_out,
    input wire logic [4:0] dividend_quotient_operand_in, remainder_operand_in
);
    import sdiv_pkg::*;
    // opcode match and single-quotient-write cases
    wire logic hit = instr_in[10:5] == SDIV_LO_PAT && instr_in[26:16] == SDIV_HI_WORD;
    wire logic one_q = two_operand_in || dividend_quotient_operand_in != remainder_operand_in;
    wire logic [2:0] fl = {overflow_flag_out, sign_flag_out, zero_flag_out};
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    a_start_busy: assert property (start_in && !busy_out |=> busy_out) else $error("busy");
    a_quiet_start: assert property (start_in && !busy_out |=> !wr_en_out [*8]) else $error("early");
    a_abort_clean: assert property (abort_out |-> !wr_en_out && !flags_we_out) else $error("commit");
    a_abort_cause: assert property (abort_out |-> $past(interrupt_in)) else $error("cause");
    a_done_idle: assert property (done_out |-> !busy_out) else $error("done");
    a_flag_hold: assert property (!flags_we_out |-> $stable(fl)) else $error("hold");
    a_flag_match: assert property (flags_we_out && one_q |->
        fl[1:0] == {wr_data_out[31], wr_data_out == '0}) else $error("flags");
    a_abort_quiet: assert property (abort_out |=> !wr_en_out [*8]) else $error("late write");
    a_decode_late: assert property (!$past(reset_in) |-> word_decode_out == $past(hit)) else $error("dec");
endmodule : sdiv_checker
bind sdiv_unit sdiv_checker chk (.*);

// file: tb/sdiv_rf.sv
`timescale 1ns/100ps
module sdiv_rf (
    input wire logic ref_clk_in,
    input wire logic we_in,
    input wire logic [4:0] wa_in,
    input wire logic [31:0] wd_in,
    input wire logic [4:0] ra0_in,
    input wire logic [4:0] ra1_in,
    output logic [31:0] rd0_out,
    output logic [31:0] rd1_out
);
    logic [31:0] regs [32];
    // one write port from the divider; the divisor is never written here
    always @(posedge ref_clk_in) if (we_in) regs[wa_in] <= wd_in;
    // two combinational read ports feeding the operands
    assign rd0_out = regs[ra0_in];
    assign rd1_out = regs[ra1_in];
endmodule : sdiv_rf

// file: tb/signed_word_halfword_divider_bench.sv
`timescale 1ns/100ps
module signed_word_halfword_divider_bench;
    import sdiv_pkg::*;
    logic ref_clk_in = 0, reset_in = 1, start_in = 0, halfword_in = 0, two_operand_in = 0, interrupt_in = 0;
    logic busy_out, word_decode_out, abort_out, done_out, wr_en_out, flags_we_out;
    logic overflow_flag_out, sign_flag_out, zero_flag_out;
    logic [4:0] wr_addr_out, da = 5'h01, qa = 5'h02, ra = 5'h03;
    logic [31:0] instr_in = '0, wr_data_out, divisor_data_in, dividend_data_in;
    wire logic [2:0] fl = {overflow_flag_out, sign_flag_out, zero_flag_out};
    int failures = 0, n_compared = 0;
    sdiv_unit uut (.divisor_operand_in(da), .dividend_quotient_operand_in(qa), .remainder_operand_in(ra), .*);
    // register file model with its read ports on the operand addresses
    sdiv_rf rf (.ref_clk_in, .we_in(wr_en_out), .wa_in(wr_addr_out), .wd_in(wr_data_out),
        .ra0_in(da), .ra1_in(qa), .rd0_out(divisor_data_in), .rd1_out(dividend_data_in));
    initial forever #50 ref_clk_in = ~ref_clk_in;
    task automatic chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    // one division; irq above zero raises the interrupt that many cycles in
    task automatic div_case(input logic [31:0] a, b, input logic hw, two, input int irq);
        logic [31:0] bx, q, r;
        logic [2:0] f0;
        logic ovf, abt;
        bx = hw ? {{16{b[15]}}, b[15:0]} : b;
        ovf = bx == '0 || (a == SDIV_MOST_NEG && bx == SDIV_MINUS_ONE);
        // an interrupt counts only while the steps still run; later it meets the write states
        abt = irq > 0 && irq < SDIV_STEPS;
        // signed division kept apart from unsigned operands so it stays signed
        if (ovf) begin
            q = SDIV_MOST_NEG;
            r = (bx == '0) ? a : '0; // nothing divides out of a zero divisor
        end else begin
            q = $signed(a) / $signed(bx);
            r = $signed(a) % $signed(bx);
        end
        f0 = fl;
        // marker first, so a shared destination still starts from the dividend
        rf.regs[ra] = 32'h5A5A_5A5A;
        rf.regs[qa] = a;
        rf.regs[da] = b;
        halfword_in = hw;
        two_operand_in = two;
        instr_in = hw ? '0 : {ra, SDIV_HI_WORD, qa, SDIV_LO_PAT, da};
        start_in = 1;
        @(negedge ref_clk_in) start_in = 0;
        chk(32'(word_decode_out), 32'(!hw));
        repeat (irq) @(negedge ref_clk_in);
        interrupt_in = irq > 0;
        for (int n = 0; n < 60 && !done_out && !abort_out; n++) @(negedge ref_clk_in);
        chk(32'(abort_out), 32'(abt));
        interrupt_in = 0;
        repeat (2) @(negedge ref_clk_in);
        chk(rf.regs[da], b);
        if (abt) begin
            chk(rf.regs[qa], a);
            chk(32'(fl), 32'(f0));
        end else begin
            chk(rf.regs[qa], (qa == ra && !two) ? r : q);
            chk(rf.regs[ra], two ? 32'h5A5A_5A5A : r);
            chk(32'(fl), 32'({ovf, q[31], q == '0}));
        end
    endtask : div_case
    task automatic t_word;
        div_case(32'h0000_0064, 32'hFFFF_FFF9, 0, 0, 0);
        div_case(32'h0000_0005, 32'h0000_0007, 0, 0, 0);
        div_case(SDIV_MOST_NEG, SDIV_MINUS_ONE, 0, 0, 0);
        ra = qa;
        div_case(32'hFFFF_FF9C, 32'h0000_0007, 0, 0, 0);
        ra = 5'h03;
        $display("t_word end");
    endtask : t_word
    task automatic t_half;
        div_case(32'hFFFF_FFF6, 32'h1234_FFFD, 1, 0, 0);
        div_case(32'h0000_04D2, 32'hABCD_0000, 1, 1, 0);
        $display("t_half end");
    endtask : t_half
    task automatic t_abort;
        div_case(32'h0000_0064, 32'h0000_0009, 0, 0, 10);
        div_case(32'h0000_0064, 32'h0000_0009, 0, 0, 0);
        div_case(32'h0000_0064, 32'h0000_0009, 0, 0, SDIV_STEPS); // ignored in write states
        $display("t_abort end");
    endtask : t_abort
    initial begin
        repeat (4) @(negedge ref_clk_in);
        reset_in = 0;
        t_word;
        t_half;
        t_abort;
        wrap_up;
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        failures++;
        wrap_up;
    end
endmodule : signed_word_halfword_divider_bench
